// ===== hw/map_memory.v
`timescale 1ns/100ps
`default_nettype none
module map_memory #(
  parameter AW = 4,
  parameter DW = 8
) (
  input  wire          clk_sys_i,
  input  wire          rstn_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [DW-1:0] rdata_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // array has no reset, contents are user scratch only
  always @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= {DW{1'b0}};
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // map_memory
`default_nettype wire

// ===== hw/module_sideband_control.v
`timescale 1ns/100ps
`default_nettype none
`include "sideband_defs.vh"
module module_sideband_control #(
  parameter LANES     = 4,
  parameter RESET_CYC = `RESET_MIN_CYC,
  parameter INIT_CYC  = `INIT_CYC
) (
  input  wire               clk_sys_i,
  input  wire               rstn_i,
  input  wire               module_select_n_i,
  input  wire               module_reset_n_i,
  input  wire               low_power_select_i,
  input  wire               transmit_disable_i,
  input  wire               scl_i,
  input  wire               sda_i,
  input  wire [LANES*8-1:0] rx_power_i,
  output reg                sda_o,
  output reg                sda_oe_n_o,
  output reg                interrupt_n_o,
  output reg                presence_detect_n_o,
  output reg                tx_off_o,
  output reg                power_cap_o,
  output reg                receive_signal_loss_o
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_IDLE  = 3'd0;
  localparam S_ADDR  = 3'd1;
  localparam S_ACKA  = 3'd2;
  localparam S_WRITE = 3'd3;
  localparam S_ACKW  = 3'd4;
  localparam S_READ  = 3'd5;
  localparam S_ACKR  = 3'd6;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // order: sda, scl, tx disable, low power, reset, select
  reg  [5:0] sync1_q;
  reg  [5:0] sync2_q;
  reg        scl_d_q;
  reg        sda_d_q;
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= `SYNC_RESET;
      sync2_q <= `SYNC_RESET;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      sync1_q <= {sda_i, scl_i, transmit_disable_i, low_power_select_i,
                  module_reset_n_i, module_select_n_i};
      sync2_q <= sync1_q;
      scl_d_q <= sync2_q[4];
      sda_d_q <= sync2_q[5];
    end
  end
  wire sel_n  = sync2_q[0];
  wire rst_n  = sync2_q[1];
  wire scl    = sync2_q[4];
  wire sda    = sync2_q[5];
  wire scl_rise = scl & ~scl_d_q;
  wire scl_fall = ~scl & scl_d_q;
  wire start_c  = scl & scl_d_q & sda_d_q & ~sda;
  wire stop_c   = scl & scl_d_q & ~sda_d_q & sda;

  // ----------------------------------------
  // reset pulse qualification and init
  // ----------------------------------------
  reg [15:0] low_cnt_q;
  reg        soft_rst_q;
  reg [15:0] init_cnt_q;
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt_q  <= 16'h0000;
      soft_rst_q <= 1'b0;
    end else if (rst_n) begin
      low_cnt_q  <= 16'h0000;
      soft_rst_q <= 1'b0;
    end else if (low_cnt_q >= RESET_CYC[15:0]) begin
      soft_rst_q <= 1'b1;
    end else begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  // power-up loads the init count too, so no reset pulse is needed
  wire init_done = (init_cnt_q == 16'h0001);
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_cnt_q <= 16'hffff;
    end else if (soft_rst_q || init_cnt_q == 16'hffff) begin
      init_cnt_q <= INIT_CYC[15:0];
    end else if (init_cnt_q != 16'h0000) begin
      init_cnt_q <= init_cnt_q - 16'h0001;
    end
  end

  // ----------------------------------------
  // monitor and alarms
  // ----------------------------------------
  reg [LANES*8-1:0] mon_q;
  reg [LANES-1:0]   los_q;
  integer i;
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mon_q <= {LANES*8{1'b0}};
      los_q <= {LANES{1'b0}};
    end else begin
      mon_q <= rx_power_i;
      for (i = 0; i < LANES; i = i + 1) begin
        los_q[i] <= (rx_power_i[i*8 +: 8] < `LOS_THRESH);
      end
    end
  end

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  reg  [2:0] st_q;
  reg  [3:0] cnt_q;
  reg  [7:0] shift_q;
  reg  [7:0] tx_q;
  reg  [7:0] ptr_q;
  reg        rw_q;
  reg        first_q;
  reg        nack_q;
  reg        drive_q;
  reg        mem_we_q;
  reg  [7:0] ctrl_q;
  reg        not_ready_q;
  reg        int_q;
  wire [7:0] mem_rd;
  reg  [7:0] rd_byte;
  reg        rd_status;

  always @* begin
    rd_status = 1'b0;
    rd_byte   = 8'h00;
    if (ptr_q == `OFS_STATUS) begin
      rd_byte   = {6'h00, int_q, not_ready_q};
      rd_status = 1'b1;
    end else if (ptr_q == `OFS_LOS) begin
      rd_byte = {{(8-LANES){1'b0}}, los_q};
    end else if (ptr_q >= `OFS_MON0 && ptr_q < `OFS_MON0 + LANES) begin
      rd_byte = mon_q[(ptr_q - `OFS_MON0) * 8 +: 8];
    end else if (ptr_q == `OFS_CTRL) begin
      rd_byte = ctrl_q;
    end else if (ptr_q[7:4] == `OFS_MEM_HI) begin
      rd_byte = mem_rd;
    end
  end

  wire load_rd = scl_fall && (st_q == S_ACKA ? rw_q : (st_q == S_ACKR && !nack_q));
  wire wr_byte = scl_fall && st_q == S_WRITE && cnt_q == 4'd8 && !first_q;

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q     <= S_IDLE;
      cnt_q    <= 4'd0;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 8'h00;
      rw_q     <= 1'b0;
      first_q  <= 1'b1;
      nack_q   <= 1'b0;
      drive_q  <= 1'b0;
      mem_we_q <= 1'b0;
      ctrl_q   <= `CTRL_RESET;
    end else if (soft_rst_q || sel_n) begin
      // deselect drops the bus at once, the line is released
      st_q     <= S_IDLE;
      drive_q  <= 1'b0;
      mem_we_q <= 1'b0;
      if (soft_rst_q) begin
        ctrl_q <= `CTRL_RESET;
        ptr_q  <= 8'h00;
      end
    end else begin
      mem_we_q <= wr_byte && ptr_q[7:4] == `OFS_MEM_HI;
      if (mem_we_q) begin
        ptr_q <= ptr_q + 8'h01;
      end
      if (start_c) begin
        st_q    <= S_ADDR;
        cnt_q   <= 4'd0;
        first_q <= 1'b1;
        drive_q <= 1'b0;
      end else if (stop_c) begin
        st_q    <= S_IDLE;
        drive_q <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == S_ADDR || st_q == S_WRITE || st_q == S_READ) begin
          shift_q <= {shift_q[6:0], sda};
          cnt_q   <= cnt_q + 4'd1;
        end else if (st_q == S_ACKR) begin
          nack_q <= sda;
          if (!sda) begin
            ptr_q <= ptr_q + 8'h01;
          end
        end
      end else if (scl_fall) begin
        case (st_q)
          S_ADDR: begin
            if (cnt_q == 4'd8) begin
              cnt_q <= 4'd0;
              if (shift_q[7:1] == `DEV_ADDR) begin
                st_q    <= S_ACKA;
                drive_q <= 1'b1;
                rw_q    <= shift_q[0];
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_ACKA, S_ACKR: begin
            cnt_q <= 4'd0;
            if (load_rd) begin
              st_q    <= S_READ;
              tx_q    <= rd_byte;
              drive_q <= ~rd_byte[7];
            end else begin
              st_q    <= (st_q == S_ACKA) ? S_WRITE : S_IDLE;
              drive_q <= 1'b0;
            end
          end
          S_WRITE: begin
            if (cnt_q == 4'd8) begin
              st_q    <= S_ACKW;
              drive_q <= 1'b1;
              cnt_q   <= 4'd0;
              first_q <= 1'b0;
              if (first_q) begin
                ptr_q <= shift_q;
              end else if (ptr_q == `OFS_CTRL) begin
                ctrl_q <= shift_q;
                ptr_q  <= ptr_q + 8'h01;
              end else if (ptr_q[7:4] != `OFS_MEM_HI) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          S_ACKW: begin
            st_q    <= S_WRITE;
            drive_q <= 1'b0;
          end
          S_READ: begin
            if (cnt_q == 4'd8) begin
              st_q    <= S_ACKR;
              drive_q <= 1'b0;
            end else begin
              tx_q    <= {tx_q[6:0], 1'b0};
              drive_q <= ~tx_q[6];
            end
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // status flags, set wins over the read clear
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      not_ready_q <= 1'b1;
      int_q       <= 1'b0;
    end else if (soft_rst_q) begin
      not_ready_q <= 1'b1;
      int_q       <= 1'b0;
    end else if (init_done) begin
      not_ready_q <= 1'b0;
      int_q       <= 1'b1;
    end else if (load_rd && rd_status && !sel_n) begin
      int_q <= 1'b0;
    end
  end

  map_memory #(.AW(4), .DW(8)) u_mem (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .we_i      (mem_we_q),
    .waddr_i   (ptr_q[3:0]),
    .wdata_i   (shift_q),
    .raddr_i   (ptr_q[3:0]),
    .rdata_o   (mem_rd)
  );

  // ----------------------------------------
  // registered pin outputs
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_o                 <= 1'b0;
      sda_oe_n_o            <= 1'b1;
      interrupt_n_o         <= 1'b1;
      presence_detect_n_o   <= 1'b0;
      tx_off_o              <= 1'b1;
      power_cap_o           <= 1'b1;
      receive_signal_loss_o <= 1'b0;
    end else begin
      sda_o                 <= 1'b0;
      sda_oe_n_o            <= ~(drive_q & ~sel_n);
      interrupt_n_o         <= ~int_q;
      presence_detect_n_o   <= 1'b0;
      tx_off_o              <= sync2_q[3] | ctrl_q[`CTRL_TX_OFF];
      power_cap_o           <= sync2_q[2];
      receive_signal_loss_o <= |los_q;
    end
  end
endmodule // module_sideband_control
`default_nettype wire

// ===== hw/sideband_defs.vh
`ifndef SIDEBAND_DEFS_VH
`define SIDEBAND_DEFS_VH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_MHZ          25
`define RESET_MIN_NS     10000
`define RESET_MIN_CYC    ((`RESET_MIN_NS * `CLK_MHZ + 999) / 1000)
`define INIT_NS          100000
`define INIT_CYC         ((`INIT_NS * `CLK_MHZ) / 1000)
// ----------------------------------------
// serial bus
// ----------------------------------------
`define DEV_ADDR         7'h50
// ----------------------------------------
// memory map offsets
// ----------------------------------------
`define OFS_STATUS       8'h00
`define OFS_LOS          8'h01
`define OFS_MON0         8'h02
`define OFS_CTRL         8'h06
`define OFS_MEM_HI       4'h1
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ST_NOT_READY     0
`define ST_INT_FLAG      1
`define CTRL_TX_OFF      0
`define CTRL_RESET       8'h00
`define LOS_THRESH       8'h10
`define SYNC_RESET       6'h33
`endif

// ===== verification/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------
// host side of the two-wire bus
// ---------------------------------
module host_model (
  input  wire logic clk_sys_i,
  output var  logic scl_o,
  output var  logic sda_o,
  input  wire logic sda_i
);
  // host owns the clock and parks it high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // one bit is 8 clocks (320 ns): 5 low, 3 high; the module lets go of its bit before the rise
  task automatic bit_x(input logic b, output logic r);
    scl_o <= 1'b0;
    cyc(2);
    sda_o <= b;
    cyc(3);
    scl_o <= 1'b1;
    cyc(3);
    r = sda_i;
  endtask
  // start is a=1 b=0, stop is a=0 b=1
  task automatic edge_x(input logic a, input logic b);
    scl_o <= 1'b0;
    cyc(2);
    sda_o <= a;
    cyc(3);
    scl_o <= 1'b1;
    cyc(2);
    sda_o <= b;
    cyc(3);
  endtask
  task automatic start();
    edge_x(1'b1, 1'b0);
  endtask
  task automatic stop();
    edge_x(1'b0, 1'b1);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_x(1'b1, r);
      d = {d[6:0], r};
    end
    bit_x(~more, r);
  endtask
endmodule // host_model
`default_nettype wire

// ===== verification/module_sideband_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sideband_defs.vh"
module module_sideband_control_tb_top;
  localparam int INIT = 1500;
  localparam logic [7:0] WA = {`DEV_ADDR, 1'b0};
  logic clk_sys_i, rstn_i, module_select_n_i, module_reset_n_i, low_power_select_i, transmit_disable_i;
  logic scl_i, host_sda, ok;
  logic sda_o, sda_oe_n_o, interrupt_n_o, presence_detect_n_o, tx_off_o, power_cap_o, receive_signal_loss_o;
  logic [31:0] rx_power_i;
  wire         sda_i;
  int          fails, n_checks;
  logic [7:0]  q [$];
  logic [7:0]  exp6 [6] = '{8'h08, 8'h40, 8'h20, 8'h30, 8'h0f, 8'h01};
  // {disable pin, low power, lane powers, tx off, power cap, loss}
  logic [36:0] rows [5] = '{{2'b00, 32'h20202020, 3'b000}, {2'b10, 32'h20202020, 3'b100},
    {2'b01, 32'h10101010, 3'b010}, {2'b00, 32'h2020200f, 3'b001}, {2'b11, 32'h0f202020, 3'b111}};
  // open-drain wire: low if either side pulls, pulled up otherwise
  assign sda_i = host_sda & sda_oe_n_o;
  module_sideband_control #(.RESET_CYC(4), .INIT_CYC(INIT)) dut (.clk_sys_i, .rstn_i, .module_select_n_i,
    .module_reset_n_i, .low_power_select_i, .transmit_disable_i, .scl_i, .sda_i, .rx_power_i, .sda_o,
    .sda_oe_n_o, .interrupt_n_o, .presence_detect_n_o, .tx_off_o, .power_cap_o, .receive_signal_loss_o);
  host_model h (.clk_sys_i, .scl_o(scl_i), .sda_o(host_sda), .sda_i);
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task finish_test;
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    logic k1, k2, k3;
    h.start();
    h.wr_byte(a, k1);
    h.wr_byte(p, k2);
    h.wr_byte(d, k3);
    h.stop();
    ok = k1 & k2 & k3;
  endtask
  task rd(input logic [7:0] p, input int n);
    logic k;
    logic [7:0] b;
    q = {};
    h.start();
    h.wr_byte(WA, k);
    h.wr_byte(p, k);
    h.start();
    h.wr_byte(WA | 8'h01, k);
    for (int i = 0; i < n; i++) begin
      h.rd_byte(i < n - 1, b);
      q.push_back(b);
    end
    h.stop();
  endtask
  initial begin
    cyc(20000);
    fails++;
    finish_test();
  end
  initial begin
    rstn_i = 1'b0;
    module_select_n_i = 1'b0;
    module_reset_n_i = 1'b1;
    low_power_select_i = 1'b0;
    transmit_disable_i = 1'b0;
    rx_power_i = 32'h20202020;
    cyc(5);
    rstn_i <= 1'b1;
    cyc(2);
    chk(presence_detect_n_o, 1'b0);
    rd(`OFS_STATUS, 1);
    chk(q[0], 8'h01);
    foreach (rows[i]) begin
      {transmit_disable_i, low_power_select_i, rx_power_i} <= rows[i][36:3];
      cyc(8);
      chk(tx_off_o, rows[i][2]);
      chk(power_cap_o, rows[i][1]);
      chk(receive_signal_loss_o, rows[i][0]);
      chk(sda_o, 1'b0);
    end
    {transmit_disable_i, low_power_select_i, rx_power_i} <= {2'b00, 32'h0f302040};
    cyc(INIT);
    // status is trusted only once the interrupt says init is over
    chk(interrupt_n_o, 1'b0);
    rd(`OFS_STATUS, 1);
    chk(q[0], 8'h02);
    chk(interrupt_n_o, 1'b1);
    wr(WA, `OFS_CTRL, 8'h01);
    chk(ok, 1'b1);
    cyc(4);
    chk(tx_off_o, 1'b1);
    rd(`OFS_LOS, 6);
    foreach (exp6[i]) chk(q[i], exp6[i]);
    wr(WA, 8'h10, 8'h5a);
    chk(ok, 1'b1);
    rd(8'h10, 1);
    chk(q[0], 8'h5a);
    rd(8'h07, 1);
    chk(q[0], 8'h00);
    module_select_n_i <= 1'b1;
    cyc(4);
    wr(WA, `OFS_CTRL, 8'h00);
    chk(ok, 1'b0);
    chk(tx_off_o, 1'b1);
    module_select_n_i <= 1'b0;
    module_reset_n_i <= 1'b0;
    cyc(2);
    module_reset_n_i <= 1'b1;
    cyc(8);
    chk(tx_off_o, 1'b1);
    module_reset_n_i <= 1'b0;
    cyc(18);
    chk(tx_off_o, 1'b0);
    module_reset_n_i <= 1'b1;
    cyc(INIT + 20);
    chk(interrupt_n_o, 1'b0);
    finish_test();
  end
endmodule // module_sideband_control_tb_top
`default_nettype wire

// ===== verification/sideband_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "sideband_defs.vh"
// ---------------------------------
// pin-level checks
// ---------------------------------
module sideband_chk #(
  parameter LANES     = 4,
  parameter RESET_CYC = `RESET_MIN_CYC,
  parameter INIT_CYC  = `INIT_CYC
) (
  input wire logic               clk_sys_i,
  input wire logic               rstn_i,
  input wire logic               module_select_n_i,
  input wire logic               module_reset_n_i,
  input wire logic               low_power_select_i,
  input wire logic               transmit_disable_i,
  input wire logic               scl_i,
  input wire logic               sda_i,
  input wire logic [LANES*8-1:0] rx_power_i,
  input wire logic               sda_o,
  input wire logic               sda_oe_n_o,
  input wire logic               interrupt_n_o,
  input wire logic               presence_detect_n_o,
  input wire logic               tx_off_o,
  input wire logic               power_cap_o,
  input wire logic               receive_signal_loss_o
);
  logic [15:0] lo_cnt_q;
  logic [15:0] up_cnt_q;
  logic        los_now;
  always_comb begin
    los_now = 1'b0;
    for (int i = 0; i < LANES; i++)
      if (rx_power_i[8*i+:8] < `LOS_THRESH) los_now = 1'b1;
  end
  // restart the init count only once the pulse is surely past the minimum, short pulses must not
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lo_cnt_q <= 16'h0;
      up_cnt_q <= 16'h0;
    end else begin
      lo_cnt_q <= module_reset_n_i ? 16'h0 : lo_cnt_q + 16'h1;
      up_cnt_q <= (lo_cnt_q >= RESET_CYC + 8) ? 16'h0 : up_cnt_q + 16'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_present; presence_detect_n_o == 1'b0; endproperty
  a_present: assert property (p_present) else $error("presence not low");
  property p_tx_pin; transmit_disable_i [*5] |-> tx_off_o; endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("tx not off");
  property p_sync; $rose(transmit_disable_i) && !tx_off_o |=> !tx_off_o; endproperty
  a_sync: assert property (p_sync) else $error("pin used unsynced");
  property p_cap_on; low_power_select_i [*5] |-> power_cap_o; endproperty
  a_cap_on: assert property (p_cap_on) else $error("power not capped");
  property p_cap_off; !low_power_select_i [*5] |-> !power_cap_o; endproperty
  a_cap_off: assert property (p_cap_off) else $error("power capped");
  property p_los; ($stable(rx_power_i)) [*4] |-> receive_signal_loss_o == los_now; endproperty
  a_los: assert property (p_los) else $error("loss flag wrong");
  property p_desel; module_select_n_i [*4] |=> sda_oe_n_o; endproperty
  a_desel: assert property (p_desel) else $error("drives bus unselected");
  property p_init_wait; up_cnt_q < INIT_CYC |-> interrupt_n_o; endproperty
  a_init_wait: assert property (p_init_wait) else $error("early interrupt");
  property p_int_done; up_cnt_q == INIT_CYC + 12 |-> !interrupt_n_o; endproperty
  a_int_done: assert property (p_int_done) else $error("no reset interrupt");
  property p_soft; !transmit_disable_i [*5] ##0 lo_cnt_q >= RESET_CYC + 8 |-> !tx_off_o && interrupt_n_o; endproperty
  a_soft: assert property (p_soft) else $error("soft reset kept state");
  c_int: cover property ($fell(interrupt_n_o));
  c_ack: cover property (!sda_oe_n_o);
  c_soft: cover property (lo_cnt_q == RESET_CYC + 8);
endmodule // sideband_chk
bind module_sideband_control sideband_chk #(.LANES(LANES), .RESET_CYC(RESET_CYC), .INIT_CYC(INIT_CYC)) u_chk (
  .clk_sys_i, .rstn_i, .module_select_n_i, .module_reset_n_i, .low_power_select_i, .transmit_disable_i,
  .scl_i, .sda_i, .rx_power_i, .sda_o, .sda_oe_n_o, .interrupt_n_o, .presence_detect_n_o, .tx_off_o,
  .power_cap_o, .receive_signal_loss_o);
`default_nettype wire
